// ===== include/nvm_cmd_pkg.sv
// constants, register map and command encodings of the nvm command controller
package nvm_cmd_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CLKDIV = 6'h00;
  localparam logic [5:0] IDX_PINDEX = 6'h02;
  localparam logic [5:0] IDX_STATUS = 6'h06;
  localparam logic [5:0] IDX_FAULT = 6'h07;
  localparam logic [5:0] IDX_PARAM_HI = 6'h0a;
  localparam logic [5:0] IDX_PARAM_LO = 6'h0b;
  localparam logic [5:0] IDX_RSV_ONE = 6'h0c;
  localparam logic [5:0] IDX_RSV_TWO = 6'h0d;
  localparam logic [5:0] IDX_RSV_THREE = 6'h0e;
  localparam logic [5:0] IDX_MARGIN = 6'h10;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ST_CMD_DONE = 7;
  localparam int ST_ACC_ERR = 5;
  localparam int ST_PROT_VIOL = 4;
  localparam int ST_MEM_ONE = 1;
  localparam int ST_MEM_ZERO = 0;
  localparam int FLT_DOUBLE = 1;
  localparam int FLT_SINGLE = 0;
  localparam int DIV_LOADED = 7;
  // ----------------------------------------------------------------
  // commands, block codes, margin levels
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_VERIFY_ALL = 8'h01;
  localparam logic [7:0] CMD_SET_MARGIN = 8'h0e;
  localparam logic [7:0] CMD_PROGRAM = 8'h06;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h08;
  localparam logic [7:0] CMD_ERASE_BLOCK = 8'h09;
  localparam logic [7:0] CMD_ERASE_SECTOR = 8'h0a;
  localparam logic [7:0] CMD_PROGRAM_EE = 8'h11;
  localparam logic [7:0] CMD_ERASE_EE = 8'h12;
  localparam logic [2:0] PIDX_VERIFY = 3'h0;
  localparam logic [2:0] PIDX_MARGIN = 3'h1;
  localparam logic [1:0] BLK_PFLASH = 2'h0;
  localparam logic [1:0] BLK_EEPROM = 2'h1;
  localparam logic [15:0] MRG_NORMAL = 16'h0000;
  localparam logic [15:0] MRG_USER_ONE = 16'h0001;
  localparam logic [15:0] MRG_USER_ZERO = 16'h0002;
  localparam logic [15:0] MRG_FIELD_ONE = 16'h0003;
  localparam logic [15:0] MRG_FIELD_ZERO = 16'h0004;
  localparam logic [0:0] RD_PFLASH = 1'h0;
  localparam logic [0:0] RD_EEPROM = 1'h1;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int VERIFY_NS = 640;
  localparam int MARGIN_NS = 50;
  localparam int ALGO_NS = 2000;
  localparam logic [7:0] VERIFY_CYC = 8'((VERIFY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] MARGIN_CYC = 8'((MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] ALGO_CYC = 8'((ALGO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_VERIFY = 4'b0010,
    ST_MARGIN = 4'b0100,
    ST_ALGO = 4'b1000
  } seq_state_e;
endpackage : nvm_cmd_pkg

// ===== design/flash_command_controller.sv
// command sequencer of the nvm controller with classic wishbone register slave
`timescale 1ns/10ps
`default_nettype none
module flash_command_controller
  import nvm_cmd_pkg::*;
(
  input wire logic ref_clk, // 100 MHz clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write enable
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte selects
  input wire logic [31:0] wb_dat_i, // write data
  output logic wb_ack_o, // acknowledge
  output logic [31:0] wb_dat_o, // read data
  input wire logic special_mode, // high in special modes
  input wire logic pflash_blank, // program array reports erased
  input wire logic eeprom_blank, // eeprom array reports erased
  input wire logic verify_read_err, // correctable read error seen
  input wire logic verify_uncorr_err, // uncorrectable read error seen
  input wire logic array_rd_req, // array read strobe
  input wire logic array_rd_block, // 0 program, 1 eeprom
  output logic array_rd_invalid, // read data invalid, one pulse
  output logic [2:0] pflash_margin, // program read margin level
  output logic [2:0] eeprom_margin, // eeprom read margin level
  output logic cmd_busy // command running: verify, margin or program/erase
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic known_prog_erase(input logic [7:0] code);
    known_prog_erase = (code == CMD_PROGRAM) || (code == CMD_ERASE_ALL) || (code == CMD_ERASE_BLOCK) ||
                       (code == CMD_ERASE_SECTOR) || (code == CMD_PROGRAM_EE) || (code == CMD_ERASE_EE);
  endfunction : known_prog_erase

  function automatic logic valid_level(input logic [15:0] lvl);
    valid_level = (lvl <= MRG_FIELD_ZERO);
  endfunction : valid_level

  seq_state_e state_ff, nxt_state;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic div_loaded_ff;
  logic [6:0] div_ff;
  logic [2:0] pidx_ff;
  logic [15:0] param_ff [8];
  logic done_ff, acc_err_ff, prot_viol_ff, mem_one_ff, mem_zero_ff;
  logic sfd_ff, dfd_ff;
  logic err_any_ff, err_unc_ff;
  logic [7:0] cnt_ff;
  logic [2:0] pmrg_ff, emrg_ff;
  logic rd_inv_ff;
  logic busy_ff;
  logic [7:0] busy_len_ff;

  wire logic req = wb_cyc_i && wb_stb_i && !ack_ff;
  wire logic wr = req && wb_we_i && wb_sel_i[0];
  wire logic [5:0] idx = wb_adr_i[7:2];
  wire logic wr_div = wr && (idx == IDX_CLKDIV);
  wire logic wr_pidx = wr && (idx == IDX_PINDEX);
  wire logic wr_stat = wr && (idx == IDX_STATUS);
  wire logic wr_flt = wr && (idx == IDX_FAULT);
  wire logic wr_hi = wr && (idx == IDX_PARAM_HI) && done_ff;
  wire logic wr_lo = wr && (idx == IDX_PARAM_LO) && done_ff;
  wire logic rd_resv = (idx == IDX_RSV_ONE) || (idx == IDX_RSV_TWO) || (idx == IDX_RSV_THREE);

  // ----------------------------------------------------------------
  // launch checks
  // ----------------------------------------------------------------
  // a launch while an error is still pending is dropped: software owns that clear
  wire logic launch = wr_stat && wb_dat_i[ST_CMD_DONE] && done_ff && !acc_err_ff && !prot_viol_ff;
  wire logic [7:0] code = param_ff[0][15:8];
  wire logic [1:0] blk_sel = param_ff[0][1:0];
  wire logic [15:0] lvl = param_ff[1];
  wire logic is_verify = (code == CMD_VERIFY_ALL);
  wire logic is_margin = (code == CMD_SET_MARGIN);
  wire logic is_pe = known_prog_erase(code);
  wire logic verify_bad = pidx_ff != PIDX_VERIFY;
  wire logic margin_bad = (pidx_ff != PIDX_MARGIN) || !special_mode || !valid_level(lvl) ||
                          ((blk_sel != BLK_PFLASH) && (blk_sel != BLK_EEPROM));
  wire logic pe_bad = !div_loaded_ff;
  wire logic cmd_err = launch && ((is_verify && verify_bad) || (is_margin && margin_bad) ||
                       (is_pe && pe_bad) || !(is_verify || is_margin || is_pe));
  wire logic go_verify = launch && is_verify && !verify_bad;
  wire logic go_margin = launch && is_margin && !margin_bad;
  wire logic go_algo = launch && is_pe && !pe_bad;
  wire logic go_any = go_verify || go_margin || go_algo;
  wire logic cnt_end = (state_ff != ST_IDLE) && (cnt_ff == CNT_ONE);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (go_verify) begin
          nxt_state = ST_VERIFY;
        end else if (go_margin) begin
          nxt_state = ST_MARGIN;
        end else if (go_algo) begin
          nxt_state = ST_ALGO;
        end
      end
      ST_VERIFY, ST_MARGIN, ST_ALGO: begin
        if (cnt_end) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  wire logic [7:0] nxt_cnt = go_verify ? VERIFY_CYC : go_margin ? MARGIN_CYC : go_algo ? ALGO_CYC :
                             (cnt_ff != CNT_ZERO) ? cnt_ff - CNT_ONE : CNT_ZERO;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      cnt_ff <= CNT_ZERO;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  wire logic verify_end = (state_ff == ST_VERIFY) && cnt_end;
  wire logic blank_fail = !(pflash_blank && eeprom_blank);
  wire logic nxt_done = go_any ? 1'b0 : (cnt_end ? 1'b1 : done_ff);
  // hardware set wins over a write-one clear in the same cycle
  wire logic nxt_acc_err = (acc_err_ff && !(wr_stat && wb_dat_i[ST_ACC_ERR])) || cmd_err;
  wire logic nxt_prot_viol = prot_viol_ff && !(wr_stat && wb_dat_i[ST_PROT_VIOL]);
  // an uncorrectable error is a read error too, so it raises bit one as well
  wire logic nxt_mem_one = go_verify ? 1'b0 :
                           (verify_end ? (err_any_ff || verify_read_err || verify_uncorr_err || blank_fail) :
                           mem_one_ff);
  wire logic nxt_mem_zero = go_verify ? 1'b0 :
                            (verify_end ? (err_unc_ff || verify_uncorr_err || blank_fail) : mem_zero_ff);
  wire logic in_verify = state_ff == ST_VERIFY;
  wire logic nxt_err_any = go_verify ? 1'b0 : (err_any_ff || (in_verify && (verify_read_err || verify_uncorr_err)));
  wire logic nxt_err_unc = go_verify ? 1'b0 : (err_unc_ff || (in_verify && verify_uncorr_err));

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      done_ff <= 1'b1;
      acc_err_ff <= 1'b0;
      prot_viol_ff <= 1'b0;
      mem_one_ff <= 1'b0;
      mem_zero_ff <= 1'b0;
      err_any_ff <= 1'b0;
      err_unc_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      done_ff <= nxt_done;
      acc_err_ff <= nxt_acc_err;
      prot_viol_ff <= nxt_prot_viol;
      mem_one_ff <= nxt_mem_one;
      mem_zero_ff <= nxt_mem_zero;
      err_any_ff <= nxt_err_any;
      err_unc_ff <= nxt_err_unc;
      busy_ff <= !nxt_done;
    end
  end

  // ----------------------------------------------------------------
  // read-while-busy fault detect
  // ----------------------------------------------------------------
  // verify touches both arrays; program/erase is treated as touching the program array
  wire logic pflash_busy = (state_ff == ST_VERIFY) || (state_ff == ST_ALGO) ||
                           ((state_ff == ST_MARGIN) && (blk_sel == BLK_PFLASH));
  wire logic eeprom_busy = (state_ff == ST_VERIFY) || (state_ff == ST_MARGIN);
  wire logic rd_clash = array_rd_req && ((array_rd_block == RD_PFLASH) ? pflash_busy : eeprom_busy);
  wire logic nxt_sfd = (sfd_ff && !(wr_flt && wb_dat_i[FLT_SINGLE])) || rd_clash;
  wire logic nxt_dfd = (dfd_ff && !(wr_flt && wb_dat_i[FLT_DOUBLE])) || rd_clash;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sfd_ff <= 1'b0;
      dfd_ff <= 1'b0;
      rd_inv_ff <= 1'b0;
    end else begin
      sfd_ff <= nxt_sfd;
      dfd_ff <= nxt_dfd;
      rd_inv_ff <= rd_clash;
    end
  end

  // ----------------------------------------------------------------
  // margin levels
  // ----------------------------------------------------------------
  wire logic margin_end = (state_ff == ST_MARGIN) && cnt_end;
  wire logic [2:0] nxt_pmrg = (margin_end && (blk_sel == BLK_PFLASH)) ? lvl[2:0] : pmrg_ff;
  wire logic [2:0] nxt_emrg = margin_end ? lvl[2:0] : emrg_ff;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pmrg_ff <= MRG_NORMAL[2:0];
      emrg_ff <= MRG_NORMAL[2:0];
    end else begin
      pmrg_ff <= nxt_pmrg;
      emrg_ff <= nxt_emrg;
    end
  end

  // ----------------------------------------------------------------
  // registers written by software
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      div_loaded_ff <= 1'b0;
      div_ff <= 7'h00;
      pidx_ff <= 3'h0;
    end else begin
      if (wr_div && done_ff) begin
        div_ff <= wb_dat_i[6:0];
        div_loaded_ff <= 1'b1;
      end
      if (wr_pidx && done_ff) begin
        pidx_ff <= wb_dat_i[2:0];
      end
    end
  end

  // parameter words, one per index; data words 0..3 live at indices 2..5
  for (genvar gi = 0; gi < 8; gi++) begin : g_param
    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        param_ff[gi] <= 16'h0000;
      end else begin
        if (wr_hi && (pidx_ff == 3'(gi))) begin
          param_ff[gi][15:8] <= wb_dat_i[7:0];
        end
        if (wr_lo && (pidx_ff == 3'(gi))) begin
          param_ff[gi][7:0] <= wb_dat_i[7:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux and bus answer
  // ----------------------------------------------------------------
  wire logic [7:0] stat_val = {done_ff, 1'b0, acc_err_ff, prot_viol_ff, 2'b00, mem_one_ff, mem_zero_ff};
  wire logic [7:0] rd_byte = (idx == IDX_CLKDIV) ? {div_loaded_ff, div_ff} :
                             (idx == IDX_PINDEX) ? {5'h00, pidx_ff} :
                             (idx == IDX_STATUS) ? stat_val :
                             (idx == IDX_FAULT) ? {6'h00, dfd_ff, sfd_ff} :
                             (idx == IDX_PARAM_HI) ? param_ff[pidx_ff][15:8] :
                             (idx == IDX_PARAM_LO) ? param_ff[pidx_ff][7:0] :
                             (idx == IDX_MARGIN) ? {1'b0, emrg_ff, 1'b0, pmrg_ff} :
                             8'h00;
  wire logic [31:0] nxt_dat = (req && !wb_we_i && !rd_resv) ? {24'h000000, rd_byte} : 32'h00000000;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end else begin
      ack_ff <= req;
      dat_ff <= nxt_dat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign array_rd_invalid = rd_inv_ff;
  assign pflash_margin = pmrg_ff;
  assign eeprom_margin = emrg_ff;
  // busy has its own flop so the pin is not gated after the complete flag
  assign cmd_busy = busy_ff;

  // ----------------------------------------------------------------
  // busy run length, so a hung sequencer trips a small counter check
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      busy_len_ff <= CNT_ZERO;
    end else begin
      busy_len_ff <= done_ff ? CNT_ZERO : busy_len_ff + CNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  localparam int VERIFY_BOUND = 70;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  ack_pulse_a: assert property (ack_ff |=> !ack_ff) else $error("ack held two cycles");
  bad_code_a: assert property (launch && !(is_verify || is_margin || is_pe) |=> acc_err_ff && done_ff)
    else $error("unknown command not flagged");
  no_div_a: assert property (launch && is_pe && !div_loaded_ff |=> acc_err_ff && state_ff == ST_IDLE)
    else $error("program before divider load not refused");
  fault_read_a: assert property (rd_clash |=> sfd_ff && dfd_ff && array_rd_invalid)
    else $error("busy read did not set fault flags");
  verify_done_a: assert property (go_verify |=> !done_ff ##[1:VERIFY_BOUND] done_ff)
    else $error("verify did not complete in time");
  blank_fail_a: assert property (verify_end && blank_fail |=> mem_one_ff && mem_zero_ff)
    else $error("blank fail not reported");
  verify_idx_a: assert property (launch && is_verify && pidx_ff != PIDX_VERIFY |=> acc_err_ff && !prot_viol_ff)
    else $error("verify index error not flagged");
  margin_mode_a: assert property (launch && is_margin && !special_mode |=> acc_err_ff && $stable(pmrg_ff))
    else $error("margin accepted outside special mode");
  margin_both_a: assert property (margin_end && blk_sel == BLK_PFLASH |=> pflash_margin == eeprom_margin)
    else $error("program margin not applied to both");
  resv_zero_a: assert property (req && !wb_we_i && rd_resv |=> wb_ack_o && wb_dat_o == 32'h00000000)
    else $error("reserved register not zero");
  err_clear_a: assert property (acc_err_ff && !cmd_err && wr_stat && !wb_dat_i[ST_ACC_ERR] |=> acc_err_ff)
    else $error("write zero cleared access error");

  // bus answer, launch, margin, verify status and fault paths
  ack_answer_a: assert property (req |=> wb_ack_o)
    else $error("request not acknowledged");
  launch_busy_a: assert property (go_any |=> !done_ff && cmd_busy)
    else $error("launch did not clear complete flag");
  busy_len_a: assert property (busy_len_ff <= ALGO_CYC)
    else $error("command ran too long");
  pe_run_a: assert property (launch && is_pe && div_loaded_ff |=> !done_ff && state_ff == ST_ALGO)
    else $error("program after divider load refused");
  margin_done_a: assert property (go_margin |=> !done_ff ##[1:8] done_ff)
    else $error("margin command did not complete");
  margin_level_a: assert property (launch && is_margin && !valid_level(lvl) |=> acc_err_ff)
    else $error("bad margin level not flagged");
  margin_block_a: assert property (launch && is_margin && blk_sel != BLK_PFLASH && blk_sel != BLK_EEPROM
    |=> acc_err_ff) else $error("bad block code not flagged");
  margin_eep_a: assert property (margin_end && blk_sel == BLK_EEPROM |=> $stable(pflash_margin))
    else $error("eeprom margin touched program level");
  mem_one_err_a: assert property (verify_end && (err_any_ff || verify_read_err || verify_uncorr_err)
    |=> mem_one_ff) else $error("read error not on status bit one");
  mem_zero_err_a: assert property (verify_end && (err_unc_ff || verify_uncorr_err) |=> mem_zero_ff)
    else $error("uncorrectable error not on status bit zero");
  verify_clear_a: assert property (go_verify |=> !mem_one_ff && !mem_zero_ff)
    else $error("memory status not cleared at verify launch");
  fault_verify_a: assert property (state_ff == ST_VERIFY && array_rd_req |=> array_rd_invalid && sfd_ff)
    else $error("read during verify not faulted");

  verify_run_c: cover property (go_verify ##[1:VERIFY_BOUND] verify_end);
  margin_run_c: cover property (go_margin ##[1:10] margin_end);
  acc_err_c: cover property (cmd_err);
  fault_rd_c: cover property (rd_clash);
  margin_eep_c: cover property (margin_end && blk_sel == BLK_EEPROM);
endmodule : flash_command_controller
`default_nettype wire

// ===== dv/tb.sv
// self-checking testbench of the nvm command controller
`timescale 1ns/10ps
`default_nettype none
module tb
  import nvm_cmd_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic ref_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, special_mode;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic pflash_blank, eeprom_blank, verify_read_err, verify_uncorr_err;
  logic array_rd_req, array_rd_block, array_rd_invalid, cmd_busy;
  logic [2:0] pflash_margin, eeprom_margin;
  int fails, samples_checked, seed, busy_cycles, inval_cnt, k;
  logic [7:0] bh [4];
  logic [7:0] bl [4];
  logic [3:0] vin [5];
  logic [7:0] vst [5];
  logic [7:0] div;
  logic [5:0] rsv [4];
  flash_command_controller dut (.ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .special_mode(special_mode),
    .pflash_blank(pflash_blank), .eeprom_blank(eeprom_blank), .verify_read_err(verify_read_err),
    .verify_uncorr_err(verify_uncorr_err), .array_rd_req(array_rd_req),
    .array_rd_block(array_rd_block), .array_rd_invalid(array_rd_invalid),
    .pflash_margin(pflash_margin), .eeprom_margin(eeprom_margin), .cmd_busy(cmd_busy));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) begin
    if (cmd_busy === 1'b1) busy_cycles++;
    if (array_rd_invalid === 1'b1) inval_cnt++;
  end
  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check_val(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : check_val
  function automatic logic [7:0] verify_status(input logic [3:0] v);
    logic bf;
    bf = !(v[3] && v[2]);
    verify_status = {1'b1, 5'h00, v[1] || v[0] || bf, v[0] || bf};
  endfunction : verify_status
  task automatic bus(input logic we, input logic [5:0] idx, input logic [7:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= {24'h0, d};
    // ack and read data are taken at the rising edge that sees ack high; the watchdog ends a hang
    do begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : bus
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr
  task automatic rd(input string nm, input logic [5:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    check_val(nm, q, {24'h0, exp});
  endtask : rd
  task automatic launch(input logic [7:0] code, input logic [7:0] p0, input logic [15:0] p1,
                        input logic [2:0] fidx);
    wr(IDX_PINDEX, 8'h00);
    wr(IDX_PARAM_HI, code);
    wr(IDX_PARAM_LO, p0);
    wr(IDX_PINDEX, 8'h01);
    wr(IDX_PARAM_HI, p1[15:8]);
    wr(IDX_PARAM_LO, p1[7:0]);
    wr(IDX_PINDEX, {5'h00, fidx});
    busy_cycles = 0;
    wr(IDX_STATUS, 8'h80);
  endtask : launch
  task automatic finish(input logic [7:0] st, input int cyc);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (cmd_busy !== 1'b0 && n < 400);
    check_val("busy cycles", 32'(busy_cycles), 32'(cyc));
    rd("status", IDX_STATUS, st);
  endtask : finish
  task automatic margins(input logic [2:0] p, input logic [2:0] e);
    rd("margin reg", IDX_MARGIN, {1'b0, e, 1'b0, p});
    check_val("margin ports", {26'h0, eeprom_margin, pflash_margin}, {26'h0, e, p});
  endtask : margins
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    #400000;
    fails++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, array_rd_req, array_rd_block, special_mode} = 6'h0;
    {verify_read_err, verify_uncorr_err, pflash_blank, eeprom_blank} = 4'h3;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hf;
    fails = 0;
    samples_checked = 0;
    seed = 7;
    rst_b = 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd("status rst", IDX_STATUS, 8'h80);
    rd("divider rst", IDX_CLKDIV, 8'h00);
    margins(3'h0, 3'h0);
    rsv = '{IDX_RSV_ONE, IDX_RSV_TWO, IDX_RSV_THREE, 6'h3f};
    for (k = 0; k < 4; k++) begin
      wr(rsv[k], 8'($random(seed)));
      rd("reserved", rsv[k], 8'h00);
    end
    for (k = 0; k < 4; k++) begin
      bh[k] = 8'($random(seed));
      bl[k] = 8'($random(seed));
      wr(IDX_PINDEX, 8'(k + 2));
      wr(IDX_PARAM_HI, bh[k]);
      wr(IDX_PARAM_LO, bl[k]);
    end
    for (k = 0; k < 4; k++) begin
      wr(IDX_PINDEX, 8'(k + 2));
      rd("data hi", IDX_PARAM_HI, bh[k]);
      rd("data lo", IDX_PARAM_LO, bl[k]);
    end
    $display("test registers done");
    launch(CMD_PROGRAM, 8'h00, 16'h0, 3'h1);
    finish(8'ha0, 0);
    wr(IDX_STATUS, 8'h00);
    rd("zero write", IDX_STATUS, 8'ha0);
    launch(CMD_VERIFY_ALL, 8'h00, 16'h0, 3'h0);
    finish(8'ha0, 0);
    wr(IDX_STATUS, 8'h20);
    rd("one clear", IDX_STATUS, 8'h80);
    for (k = 0; k < 7; k++) begin
      special_mode <= (k != 2);
      case (k)
        0: launch(8'h55, 8'h00, 16'h0, 3'h0);
        1: launch({1'b1, 7'($random(seed))}, 8'h00, 16'h0, 3'h0);
        2: launch(CMD_SET_MARGIN, 8'h00, 16'h1, 3'h1);
        3: launch(CMD_SET_MARGIN, 8'h00, 16'h1, 3'h0);
        4: launch(CMD_SET_MARGIN, 8'h00, 16'h5, 3'h1);
        5: launch(CMD_SET_MARGIN, {6'h00, 1'b1, 1'($random(seed))}, 16'h0, 3'h1);
        default: launch(CMD_VERIFY_ALL, 8'h00, 16'h0, 3'h1);
      endcase
      finish(8'ha0, 0);
      wr(IDX_STATUS, 8'h20);
    end
    margins(3'h0, 3'h0);
    $display("test errors done");
    vin = '{4'hc, 4'h4, 4'h8, 4'he, 4'hd};
    for (k = 0; k < 5; k++) begin
      {pflash_blank, eeprom_blank, verify_read_err, verify_uncorr_err} <= vin[k];
      launch(CMD_VERIFY_ALL, 8'($random(seed)), 16'h0, 3'h0);
      finish(verify_status(vin[k]), 64);
    end
    // clean arrays again, so the busy-read run below ends with no memory status set
    {pflash_blank, eeprom_blank, verify_read_err, verify_uncorr_err} <= 4'hc;
    inval_cnt = 0;
    launch(CMD_VERIFY_ALL, 8'h00, 16'h0, 3'h0);
    array_rd_req <= 1'b1;
    array_rd_block <= 1'($random(seed));
    @(posedge ref_clk);
    array_rd_req <= 1'b0;
    finish(8'h80, 64);
    check_val("invalid pulses", 32'(inval_cnt), 32'h1);
    rd("fault", IDX_FAULT, 8'h03);
    wr(IDX_FAULT, 8'h03);
    @(posedge ref_clk);
    array_rd_req <= 1'b1;
    @(posedge ref_clk);
    array_rd_req <= 1'b0;
    rd("fault idle", IDX_FAULT, 8'h00);
    check_val("idle pulses", 32'(inval_cnt), 32'h1);
    $display("test verify done");
    special_mode <= 1'b1;
    for (k = 0; k < 5; k++) begin
      launch(CMD_SET_MARGIN, {6'h0, BLK_PFLASH}, 16'(k), 3'h1);
      finish(8'h80, 5);
      margins(3'(k), 3'(k));
      launch(CMD_SET_MARGIN, {6'h0, BLK_EEPROM}, 16'(4 - k), 3'h1);
      finish(8'h80, 5);
      margins(3'(k), 3'(4 - k));
    end
    $display("test margin done");
    div = {1'b0, 7'($random(seed))};
    wr(IDX_CLKDIV, div);
    rd("divider", IDX_CLKDIV, {1'b1, div[6:0]});
    vst = '{CMD_PROGRAM, CMD_ERASE_ALL, CMD_ERASE_BLOCK, CMD_ERASE_SECTOR, CMD_PROGRAM_EE};
    for (k = 0; k < 6; k++) begin
      launch(k < 5 ? vst[k] : CMD_ERASE_EE, 8'h00, 16'h0, 3'h1); // each command once, no word twice
      finish(8'h80, 200);
    end
    $display("test program erase done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
